// >>> inc/adccr_pkg.sv
// Register map, field layout and timing constants of the converter control block
package adccr_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_PIN_SEL  = 8'h08;
  localparam logic [7:0] ADDR_CTRL     = 8'h09;
  localparam logic [7:0] ADDR_OFS_CAL  = 8'h0A;
  localparam logic [7:0] ADDR_RES_UP   = 8'h0B;
  localparam logic [7:0] ADDR_RES_TOP  = 8'h0C;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h0D;
  localparam logic [7:0] ADDR_STAT     = 8'h0E;
  // Control register fields
  localparam int CTRL_REF   = 7;
  localparam int CTRL_DIV_H = 6;
  localparam int CTRL_DIV_L = 5;
  localparam int CTRL_RUN   = 4;
  localparam int CTRL_PWR   = 3;
  localparam int CTRL_CH_H  = 1;
  localparam int CTRL_CH_L  = 0;
  // Offset calibration fields
  localparam int CAL_EN    = 7;
  localparam int CAL_SIGN  = 6;
  localparam int CAL_MAG_H = 5;
  localparam int CAL_MAG_L = 3;
  // Status register fields
  localparam int STAT_DONE = 5;
  localparam int STAT_WAKE = 3;
  // Reset values
  localparam logic       RST_REF = 1'b0;
  localparam logic [1:0] RST_DIV = 2'b00;
  // Conversion clock choices
  localparam logic [1:0] DIV_16   = 2'b00;
  localparam logic [1:0] DIV_4    = 2'b01;
  localparam logic [1:0] DIV_64   = 2'b10;
  localparam logic [1:0] DIV_RING = 2'b11;
  localparam logic [5:0] LAST_16  = 6'h0F;
  localparam logic [5:0] LAST_4   = 6'h03;
  localparam logic [5:0] LAST_64  = 6'h3F;
  localparam logic [5:0] LAST_RING = 6'h1F;
  // Conversion length in conversion clock ticks
  localparam logic [3:0] CONV_TICKS = 4'hC;
  // Result limits
  localparam logic [12:0] RES_MAX = 13'h0FFF;
  // Shared reference pin owners
  typedef enum logic [1:0] {
    PIN_PORT  = 2'b00,
    PIN_TIMER = 2'b01,
    PIN_REF   = 2'b10
  } adccr_pin_e;
  // Converter sequencer states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adccr_state_e;
endpackage : adccr_pkg

// >>> rtl/adccr_top.sv
// Converter control, calibration and result registers
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Low four bits make port pins analog
// RQ2: Reference select: supply rail or shared pin
// RQ3: Reset gives supply reference, divide-by-16
// RQ4: Shared pin: reference, then timer, then port
// RQ5: Software never uses timer and reference together
// RQ6: Clock field picks 16, 4, 64 or ring
// RQ7: Writing run bit starts conversion
// RQ8: Run bit cleared only by hardware
// RQ9: Power bit off stops the converter
// RQ10: Channel field selects one of four inputs
// RQ11: Channel writable only when idle and flag low
// RQ12: Calibration enable applies offset correction
// RQ13: Sign bit: zero negative, one positive
// RQ14: Offset magnitude in steps of two LSBs
// RQ15: Low three calibration bits read zero
// RQ16: Result bits eleven to four in upper register
// RQ17: Completion clears run, sets flag, loads result
// RQ18: Top nibble and low byte registers too
// RQ19: Done flag set by hardware, cleared by software
// RQ20: Software sets wake enable before sleep
// RQ21: Run stays high until result update
// RQ22: Unused control bits read zero, ignore writes
module adccr_top (
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_b_in,
  // Register port
  input  wire logic [7:0]              addr_in,
  input  wire logic [7:0]              wr_data_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [7:0]              rd_data_out,
  // Timer source select from the timer control register
  input  wire logic                    timer_source_sel_in,
  // Analog front end
  input  wire logic [11:0]             analog_result_in,
  output logic      [3:0]              analog_pin_en_out,
  output logic      [1:0]              channel_sel_out,
  output logic                         conv_power_on_out,
  output logic                         ref_source_sel_out,
  output logic                         converting_out,
  // Shared pin owner and wake request
  output adccr_pkg::adccr_pin_e        shared_ref_pin_out,
  output logic                         wake_req_out
);
  import adccr_pkg::*;

  // Registers
  logic [3:0]   analog_pin_en;             // Analog enables per pin
  logic         ref_source_sel;            // Reference choice
  logic [1:0]   clk_div;                   // Conversion clock choice
  logic         conv_run;                  // Conversion in progress
  logic         conv_power_on;             // Converter powered
  logic [1:0]   channel_sel;               // Input channel
  logic         offset_cal_en;             // Calibration enable
  logic         offset_sign;               // Offset polarity
  logic [2:0]   offset_magnitude;          // Offset size
  logic [11:0]  result;                    // Last result
  logic         conv_done_flag;            // Done flag
  logic         conv_wake_en;              // Wake enable
  // Next values
  logic [3:0]   next_analog_pin_en;
  logic         next_ref_source_sel;
  logic [1:0]   next_clk_div;
  logic         next_conv_run;
  logic         next_conv_power_on;
  logic [1:0]   next_channel_sel;
  logic         next_offset_cal_en;
  logic         next_offset_sign;
  logic [2:0]   next_offset_magnitude;
  logic [11:0]  next_result;
  logic         next_conv_done_flag;
  logic         next_conv_wake_en;
  // Sequencer and divider
  adccr_state_e state;
  adccr_state_e next_state;
  logic [5:0]   div_cnt;                   // Prescaler count
  logic [5:0]   next_div_cnt;
  logic [3:0]   tick_cnt;                  // Ticks into conversion
  logic [3:0]   next_tick_cnt;
  logic         tick;                      // Conversion clock enable
  logic         done_evt;                  // Conversion completes now
  // Synchroniser on the analog result
  logic [11:0]  res_s1;
  logic [11:0]  res_s2;
  // Outputs and read path
  logic [7:0]   next_rd_data;
  adccr_pin_e   next_pin;
  logic [11:0]  corrected;

  // Last prescaler count for a clock choice
  function automatic logic [5:0] div_last(input logic [1:0] sel);
    unique case (sel)
      DIV_16:   div_last = LAST_16;
      DIV_4:    div_last = LAST_4;
      DIV_64:   div_last = LAST_64;
      DIV_RING: div_last = LAST_RING;
    endcase
  endfunction : div_last

  // Apply signed, saturated offset correction
  function automatic logic [11:0] apply_offset(input logic [11:0] raw, input logic en,
                                               input logic sgn, input logic [2:0] mag);
    logic [12:0] ofs;
    logic [12:0] sum;
    ofs = {9'h000, mag, 1'b0};
    sum = {1'b0, raw};
    if (!en) begin
      apply_offset = raw;
    end else if (sgn) begin
      sum = sum + ofs;
      apply_offset = (sum > RES_MAX) ? RES_MAX[11:0] : sum[11:0];
    end else begin
      apply_offset = (sum < ofs) ? 12'h000 : 12'(sum - ofs);
    end
  endfunction : apply_offset

  // Two-flop synchroniser for the front-end result
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      res_s1 <= 12'h000;
      res_s2 <= 12'h000;
    end else begin
      res_s1 <= analog_result_in;
      res_s2 <= res_s1;
    end
  end

  // Corrected value of the sampled result
  always_comb begin
    corrected = apply_offset(res_s2, offset_cal_en, offset_sign, offset_magnitude); // [RQ12] [RQ13] [RQ14]
  end

  // Prescaler and conversion sequencer, next values
  always_comb begin
    next_div_cnt  = div_cnt;
    next_tick_cnt = tick_cnt;
    next_state    = state;
    tick          = 1'b0;
    done_evt      = 1'b0;
    if (state == ST_CONV && conv_power_on) begin // [RQ9]
      tick = (div_cnt >= div_last(clk_div)); // [RQ6]
      next_div_cnt = tick ? 6'h00 : 6'(div_cnt + 6'h01);
    end else begin
      next_div_cnt = 6'h00;
    end
    unique case (state)
      ST_IDLE: begin
        next_tick_cnt = 4'h0;
        if (conv_run) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (tick_cnt == CONV_TICKS - 4'h1) begin
            done_evt   = 1'b1; // [RQ21]
            next_state = ST_IDLE;
          end else begin
            next_tick_cnt = tick_cnt + 4'h1;
          end
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      state    <= ST_IDLE;
      div_cnt  <= 6'h00;
      tick_cnt <= 4'h0;
    end else begin
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
    end
  end

  // Register file, next values
  always_comb begin
    next_analog_pin_en    = analog_pin_en;
    next_ref_source_sel   = ref_source_sel;
    next_clk_div          = clk_div;
    next_conv_run         = conv_run;
    next_conv_power_on    = conv_power_on;
    next_channel_sel      = channel_sel;
    next_offset_cal_en    = offset_cal_en;
    next_offset_sign      = offset_sign;
    next_offset_magnitude = offset_magnitude;
    next_result           = result;
    next_conv_done_flag   = conv_done_flag;
    next_conv_wake_en     = conv_wake_en;
    if (wr_in) begin
      unique case (addr_in)
        ADDR_PIN_SEL: begin
          next_analog_pin_en = wr_data_in[3:0]; // [RQ1] [RQ22]
        end
        ADDR_CTRL: begin
          next_ref_source_sel = wr_data_in[CTRL_REF]; // [RQ2]
          next_clk_div        = wr_data_in[CTRL_DIV_H:CTRL_DIV_L]; // [RQ6]
          next_conv_power_on  = wr_data_in[CTRL_PWR]; // [RQ9]
          // Writing one starts; writing zero is ignored
          if (wr_data_in[CTRL_RUN]) begin
            next_conv_run = 1'b1; // [RQ7] [RQ8]
          end
          // Channel locked while busy or flag pending
          if (!conv_done_flag && !conv_run) begin
            next_channel_sel = wr_data_in[CTRL_CH_H:CTRL_CH_L]; // [RQ10] [RQ11]
          end
        end
        ADDR_OFS_CAL: begin
          next_offset_cal_en    = wr_data_in[CAL_EN];
          next_offset_sign      = wr_data_in[CAL_SIGN];
          next_offset_magnitude = wr_data_in[CAL_MAG_H:CAL_MAG_L];
        end
        ADDR_STAT: begin
          // Flag can only be cleared by writing zero
          if (!wr_data_in[STAT_DONE]) begin
            next_conv_done_flag = 1'b0; // [RQ19]
          end
          next_conv_wake_en = wr_data_in[STAT_WAKE]; // [RQ20]
        end
        default: begin
          // Read-only or unmapped: no effect
        end
      endcase
    end
    // Completion overrides any clear in the same cycle
    if (done_evt) begin
      next_conv_run       = 1'b0; // [RQ17] [RQ8]
      next_conv_done_flag = 1'b1; // [RQ17] [RQ19]
      next_result         = corrected; // [RQ16] [RQ18]
    end
  end

  // Register file registers
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      analog_pin_en    <= 4'h0;
      ref_source_sel   <= RST_REF; // [RQ3]
      clk_div          <= RST_DIV; // [RQ3]
      conv_run         <= 1'b0;
      conv_power_on    <= 1'b0;
      channel_sel      <= 2'b00;
      offset_cal_en    <= 1'b0;
      offset_sign      <= 1'b0;
      offset_magnitude <= 3'h0;
      result           <= 12'h000;
      conv_done_flag   <= 1'b0;
      conv_wake_en     <= 1'b0;
    end else begin
      analog_pin_en    <= next_analog_pin_en;
      ref_source_sel   <= next_ref_source_sel;
      clk_div          <= next_clk_div;
      conv_run         <= next_conv_run;
      conv_power_on    <= next_conv_power_on;
      channel_sel      <= next_channel_sel;
      offset_cal_en    <= next_offset_cal_en;
      offset_sign      <= next_offset_sign;
      offset_magnitude <= next_offset_magnitude;
      result           <= next_result;
      conv_done_flag   <= next_conv_done_flag;
      conv_wake_en     <= next_conv_wake_en;
    end
  end

  // Read mux and shared pin owner, next values
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_PIN_SEL: next_rd_data = {4'h0, analog_pin_en}; // [RQ22]
        ADDR_CTRL:    next_rd_data = {ref_source_sel, clk_div, conv_run, conv_power_on, 1'b0, channel_sel};
        ADDR_OFS_CAL: next_rd_data = {offset_cal_en, offset_sign, offset_magnitude, 3'b000}; // [RQ15]
        ADDR_RES_UP:  next_rd_data = result[11:4]; // [RQ16]
        ADDR_RES_TOP: next_rd_data = {4'h0, result[11:8]}; // [RQ18]
        ADDR_RES_LOW: next_rd_data = result[7:0]; // [RQ18]
        ADDR_STAT:    next_rd_data = {2'b00, conv_done_flag, 1'b0, conv_wake_en, 3'b000};
        default:      next_rd_data = 8'h00;
      endcase
    end
    // Reference beats timer beats port
    if (ref_source_sel) begin
      next_pin = PIN_REF; // [RQ4] [RQ2]
    end else if (timer_source_sel_in) begin
      next_pin = PIN_TIMER; // [RQ4] [RQ5]
    end else begin
      next_pin = PIN_PORT; // [RQ4]
    end
  end

  // Output registers
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      rd_data_out        <= 8'h00;
      shared_ref_pin_out <= PIN_PORT;
      analog_pin_en_out  <= 4'h0;
      channel_sel_out    <= 2'b00;
      conv_power_on_out  <= 1'b0;
      ref_source_sel_out <= 1'b0;
      converting_out     <= 1'b0;
      wake_req_out       <= 1'b0;
    end else begin
      rd_data_out        <= next_rd_data;
      shared_ref_pin_out <= next_pin;
      analog_pin_en_out  <= next_analog_pin_en;
      channel_sel_out    <= next_channel_sel;
      conv_power_on_out  <= next_conv_power_on;
      ref_source_sel_out <= next_ref_source_sel;
      converting_out     <= next_conv_run;
      wake_req_out       <= next_conv_done_flag & next_conv_wake_en;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_run_holds: assert property (conv_run && !done_evt |=> conv_run) // [RQ8]
    else $error("run bit dropped without completion");
  a_done_update: assert property (done_evt |=> conv_done_flag && !conv_run) // [RQ17]
    else $error("completion did not set flag and clear run");
  a_result_load: assert property (done_evt |=> result[11:4] == $past(corrected[11:4])) // [RQ16]
    else $error("upper result not loaded at completion");
  a_cal_off: assert property (done_evt && !offset_cal_en |=> result == $past(res_s2)) // [RQ12]
    else $error("offset applied while calibration off");
  a_chan_locked: assert property (wr_in && addr_in == ADDR_CTRL && (conv_run || conv_done_flag) // [RQ11]
                                  |=> $stable(channel_sel))
    else $error("channel changed while locked");
  a_start_run: assert property (wr_in && addr_in == ADDR_CTRL && wr_data_in[CTRL_RUN] && !conv_run // [RQ7]
                                |=> conv_run ##1 state == ST_CONV)
    else $error("write of run bit did not start");
  a_flag_clear: assert property (conv_done_flag && wr_in && addr_in == ADDR_STAT // [RQ19]
                                 && !wr_data_in[STAT_DONE] && !done_evt |=> !conv_done_flag)
    else $error("done flag not cleared");
  a_ref_prio: assert property ($past(ref_source_sel) |-> shared_ref_pin_out == PIN_REF) // [RQ4]
    else $error("reference lost the shared pin");
  a_cal_pad: assert property (rd_in && addr_in == ADDR_OFS_CAL |=> rd_data_out[2:0] == 3'b000) // [RQ15]
    else $error("unimplemented calibration bits not zero");
  a_reset_vals: assert property ($rose(rst_b_in) |-> !ref_source_sel && clk_div == RST_DIV) // [RQ3]
    else $error("reset values wrong");
  a_div4_rate: assert property (state == ST_CONV && conv_power_on && clk_div == DIV_4 && tick // [RQ6]
                                && !done_evt && !(wr_in && addr_in == ADDR_CTRL)
                                |=> !tick [*3] ##1 tick)
    else $error("divide-by-four spacing wrong");
  a_power_stall: assert property (!conv_power_on |-> !tick) // [RQ9]
    else $error("converter advanced while powered down");

  // Pin-facing outputs mirror their registers; pin owner, flag, result and wake checks follow
  a_pin_mirror: assert property (analog_pin_en_out == analog_pin_en) // [RQ1]
    else $error("analog pin enables differ from register");
  a_ref_mirror: assert property (ref_source_sel_out == ref_source_sel) // [RQ2]
    else $error("reference choice differs from register");
  a_chan_mirror: assert property (channel_sel_out == channel_sel) // [RQ10]
    else $error("channel output differs from register");
  a_power_mirror: assert property (conv_power_on_out == conv_power_on) // [RQ9]
    else $error("power output differs from register");
  a_busy_mirror: assert property (converting_out == conv_run) // [RQ21]
    else $error("busy output differs from run bit");
  a_timer_prio: assert property (!ref_source_sel && timer_source_sel_in |=> shared_ref_pin_out == PIN_TIMER) // [RQ4]
    else $error("timer did not get the shared pin");
  a_flag_no_set: assert property (!conv_done_flag && !done_evt |=> !conv_done_flag) // [RQ19]
    else $error("done flag set without completion");
  a_result_hold: assert property (!done_evt |=> $stable(result)) // [RQ16]
    else $error("result changed without completion");
  a_wake_level: assert property (wake_req_out == (conv_done_flag && conv_wake_en)) // [RQ19]
    else $error("wake request differs from flag and enable");

endmodule : adccr_top

// >>> verification/adccr_afe_model.sv
// Behavioural analog front end that feeds a raw sample for each channel
`timescale 1ns/1ps
module adccr_afe_model #(
  parameter logic [47:0] RAW_TABLE = 48'h0000_0000_0000  // Raw sample of each channel, channel 0 lowest
) (
  // Clock
  input  wire logic        clock_in,
  // Converter controls seen at the pins
  input  wire logic [1:0]  channel_sel_in,
  input  wire logic        power_on_in,
  // Raw sample toward the block
  output logic      [11:0] analog_result_out
);
  logic [11:0] noise = 12'h000;  // Churning value while the converter is unpowered

  // Unpowered front end never holds a stale sample
  always_ff @(posedge clock_in) begin
    noise <= ~noise ^ 12'hA55;
  end

  // Selected channel drives the sample while powered
  always_comb begin
    if (power_on_in) begin
      analog_result_out = RAW_TABLE[12 * channel_sel_in +: 12];
    end else begin
      analog_result_out = noise;
    end
  end
endmodule : adccr_afe_model

// >>> verification/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
  import adccr_pkg::*;
  localparam logic [47:0] RAW = 48'h8C1F_FA00_75A3;  // Channel samples 5A3, 007, FFA, 8C1

  logic        clock_in;    // System clock
  logic        rst_b_in;    // Synchronous reset, active low
  logic [7:0]  addr;        // Register address
  logic [7:0]  wr_data;     // Write data
  logic        wr;          // Write strobe
  logic        rd;          // Read strobe
  logic [7:0]  rd_data;     // Read data
  logic        timer_sel;   // Timer source bit
  logic [11:0] raw;         // Sample from the front end
  logic [3:0]  pin_en;      // Analog pin enables
  logic [1:0]  ch;          // Selected channel
  logic        pwr;         // Converter powered
  logic        ref_sel;     // External reference chosen
  logic        conv;        // Conversion running
  adccr_pin_e  pin_owner;   // Owner of the shared pin
  logic        wake;        // Wake request
  logic        rd_seen = 1'b0;  // Read taken at the previous edge
  logic [7:0]  exp_q[$];    // Expected read data, oldest first
  int          err_total;   // Mismatches
  int          n_tests;     // Comparisons

  // Clock at 100 MHz
  initial clock_in = 1'b0;
  always #5 clock_in = ~clock_in;

  adccr_top u_dut (
    .clock_in            (clock_in),
    .rst_b_in            (rst_b_in),
    .addr_in             (addr),
    .wr_data_in          (wr_data),
    .wr_in               (wr),
    .rd_in               (rd),
    .rd_data_out         (rd_data),
    .timer_source_sel_in (timer_sel),
    .analog_result_in    (raw),
    .analog_pin_en_out   (pin_en),
    .channel_sel_out     (ch),
    .conv_power_on_out   (pwr),
    .ref_source_sel_out  (ref_sel),
    .converting_out      (conv),
    .shared_ref_pin_out  (pin_owner),
    .wake_req_out        (wake)
  );

  adccr_afe_model #(.RAW_TABLE(RAW)) u_afe (
    .clock_in          (clock_in),
    .channel_sel_in    (ch),
    .power_on_in       (pwr),
    .analog_result_out (raw)
  );

  // Prints the verdict and ends the run
  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0 && exp_q.size() == 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Compares one value and counts it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write, strobe left up for a following write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clock_in);
  endtask : wr_reg

  // One-cycle read, expectation noted for the watcher
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    exp_q.push_back(e);
    @(posedge clock_in);
  endtask : rd_reg

  // Drops strobes and moves to a settled sampling point
  task automatic look(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(negedge clock_in);
  endtask : look

  // Conversion clock period for a clock field code
  function automatic int tick(input logic [1:0] d);
    case (d)
      DIV_4:    return 4;
      DIV_64:   return 64;
      DIV_RING: return 32;
      default:  return 16;
    endcase
  endfunction : tick

  // Bounded wait for the run flag to drop, latency checked
  task automatic wait_conv(input int t);
    int n;
    n = 0;
    wr <= 1'b0;
    rd <= 1'b0;
    while (conv !== 1'b0 && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
      report_and_stop();
    end else begin
      chk(8'(n >= 11 * t && n <= 13 * t + 4), 8'h01);
    end
    @(posedge clock_in);
  endtask : wait_conv

  // Read data stands in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_seen === 1'b1) begin
      chk(rd_data, exp_q.pop_front());
    end
    rd_seen <= rd;
  end

  // Main sequence
  initial begin
    logic [7:0]  cal;
    logic [12:0] r;
    logic [12:0] m;
    logic [1:0]  c;
    {rst_b_in, addr, wr_data, wr, rd, timer_sel} = '0;
    err_total = 0;
    n_tests = 0;
    void'($urandom(32'h0000_E7C7));
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    rd_reg(ADDR_PIN_SEL, 8'h00);
    rd_reg(ADDR_CTRL, 8'h00);
    rd_reg(ADDR_OFS_CAL, 8'h00);
    rd_reg(8'h00, 8'h00);
    wr_reg(ADDR_RES_UP, 8'hFF);
    rd_reg(ADDR_RES_UP, 8'h00);
    wr_reg(ADDR_PIN_SEL, 8'hF5);
    wr_reg(ADDR_OFS_CAL, 8'hFF);
    wr_reg(ADDR_CTRL, 8'h84);
    rd_reg(ADDR_PIN_SEL, 8'h05);
    rd_reg(ADDR_OFS_CAL, 8'hF8);
    rd_reg(ADDR_CTRL, 8'h80);
    look(2);
    chk({4'h0, pin_en}, 8'h05);
    chk({7'h00, ref_sel}, 8'h01);
    chk({6'h00, pin_owner}, {6'h00, PIN_REF});
    @(posedge clock_in);
    // Every clock field and channel, with offsets of both signs
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      cal = {i != 0, 7'($urandom())};
      if (i == 1) cal[6:3] = 4'h7;
      if (i == 2) cal[6:3] = 4'hF;
      wr_reg(ADDR_STAT, 8'h08);
      wr_reg(ADDR_CTRL, {1'b0, c, 3'b000, c});
      wr_reg(ADDR_OFS_CAL, cal);
      wr_reg(ADDR_CTRL, {1'b0, c, 3'b100, c});
      look(40);
      chk({7'h00, conv}, 8'h01);
      chk({7'h00, pwr}, 8'h00);
      @(posedge clock_in);
      wr_reg(ADDR_CTRL, {1'b0, c, 3'b010, ~c});
      rd_reg(ADDR_CTRL, {1'b0, c, 3'b110, c});
      wait_conv(tick(c));
      r = {1'b0, RAW[12 * i +: 12]};
      m = {9'h000, cal[5:3], 1'b0};
      if (cal[7] && cal[6]) r = r + m;
      if (cal[7] && !cal[6]) r = (r < m) ? 13'h0000 : r - m;
      if (r > RES_MAX) r = RES_MAX;
      rd_reg(ADDR_RES_UP, r[11:4]);
      rd_reg(ADDR_RES_TOP, {4'h0, r[11:8]});
      rd_reg(ADDR_RES_LOW, r[7:0]);
      rd_reg(ADDR_STAT, 8'h28);
      wr_reg(ADDR_CTRL, {1'b0, c, 3'b010, ~c});
      rd_reg(ADDR_CTRL, {1'b0, c, 3'b010, c});
      look(1);
      chk({7'h00, wake}, 8'h01);
      chk({6'h00, ch}, {6'h00, c});
      chk({7'h00, pwr}, 8'h01);
      @(posedge clock_in);
    end
    wr_reg(ADDR_STAT, 8'h00);
    wr_reg(ADDR_STAT, 8'h20);
    rd_reg(ADDR_STAT, 8'h00);
    timer_sel <= 1'b1;
    wr_reg(ADDR_CTRL, 8'h00);
    look(3);
    chk({6'h00, pin_owner}, {6'h00, PIN_TIMER});
    chk({7'h00, wake}, 8'h00);
    @(posedge clock_in);
    timer_sel <= 1'b0;
    look(3);
    chk({6'h00, pin_owner}, {6'h00, PIN_PORT});
    report_and_stop();
  end
endmodule : tb
